//--- verilog/jesd_rx_dl.sv
// Receiver deterministic-latency control with APB registers
//
// Functional notes
// RQ1: Subclass 0 or 1 only, two fields
// RQ2: Subclass 0 ignores the SYSREF input
// RQ3: Lanes within one multiframe; pairs share clock
// RQ4: Transmitter always sends alignment sequence
// RQ5: No sync error reports, subclass 0, F=1
// RQ6: Subclass 1 aligns multiframe to SYSREF
// RQ7: Transmitter keeps variation within ten cycles
// RQ8: Per-link local multiframe clock, delayed
// RQ9: Periodic delayable clock absorbs fixed delay
// RQ10: Buffer delay accepts zero to ten
// RQ11: Variation value acts as buffer delay
// RQ12: Offset in frames; 4/F frames per clock
// RQ13: Processing clock is quarter byte rate
// RQ14: Software writes identical values to both links
// RQ15: Per-link latency readback in processing clocks
// RQ16: Latency wraps modulo clocks per multiframe
// RQ17: Software computes variation and offset values
// RQ18: Latency recaptured each link establishment
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module jesd_rx_dl
  import jesd_dl_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sysrefPin,
  jesd_link_if.rx                          link,
  output logic      [LINKS-1:0][LANE_W-1:0] sampleOut,
  output logic      [LINKS-1:0]            sampleValid,
  output logic      [LINKS-1:0]            linkUp
);
  logic [7:0]             subclass_q;
  logic [7:0]             linkSub_q;
  logic [7:0]             format_q;
  logic [LINKS-1:0][7:0]  mfOffset_q;
  logic [LINKS-1:0][7:0]  bufDelay_q;
  logic [LINKS-1:0][7:0]  latency;
  logic [LINKS-1:0]       localEdge;
  logic [LINKS-1:0]       syncUp;
  logic                   sysrefMeta_q;
  logic                   sysrefSync_q;
  logic                   sysrefPrev_q;
  logic                   sysrefSeen_q;
  logic [4:0]             mfFrame_q;
  logic [4:0]             kMask;
  logic [4:0]             fpc;
  logic                   sub1;
  logic                   badSub;
  logic                   apbAccess;
  logic                   apbWrite;
  logic [11:0]            idx;
  logic                   hit;

  // Frames per processing clock is four over octets per frame
  function automatic logic [4:0] framesPerClk(input logic [2:0] f);
    unique case (f)
      3'h1:    framesPerClk = 5'h04;
      3'h2:    framesPerClk = 5'h02;
      3'h4:    framesPerClk = 5'h01;
      default: framesPerClk = 5'h02;
    endcase
  endfunction : framesPerClk

  // Only subclass 1 uses SYSREF; codes above 1 run as subclass 0
  assign sub1   = subclass_q[SUB_LSB +: SUB_W] == SUBCLASS_1; // RQ1
  assign badSub = (subclass_q[SUB_LSB +: SUB_W] > SUBCLASS_1) ||
                  (linkSub_q[LSUB_LSB +: SUB_W] > SUBCLASS_1); // RQ1
  assign kMask  = format_q[FMT_K32_BIT] ? 5'h1F : 5'h0F;
  assign fpc    = framesPerClk(format_q[FMT_F_LSB +: 3]); // RQ12 RQ13

  // SYSREF pin synchroniser and rising-edge detect
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sysrefMeta_q <= 1'b0;
      sysrefSync_q <= 1'b0;
      sysrefPrev_q <= 1'b0;
    end
    else
    begin
      sysrefMeta_q <= sysrefPin;
      sysrefSync_q <= sysrefMeta_q;
      sysrefPrev_q <= sysrefSync_q;
    end
  end

  // Shared multiframe counter in frame units, common to both links
  always_ff @(posedge clk)
  begin
    if (srst)
      mfFrame_q <= '0;
    else if (sub1 && sysrefSync_q && !sysrefPrev_q)
      mfFrame_q <= '0; // RQ6
    else
      mfFrame_q <= (mfFrame_q + fpc) & kMask; // RQ2 RQ3
  end

  // Sticky flag for SYSREF edges seen in subclass 1
  always_ff @(posedge clk)
  begin
    if (srst)
      sysrefSeen_q <= 1'b0;
    else if (sub1 && sysrefSync_q && !sysrefPrev_q)
      sysrefSeen_q <= 1'b1;
    else if (apbWrite && idx == IDX_STATUS && pwdata[ST_SYSREF_BIT])
      sysrefSeen_q <= 1'b0;
  end

  // Per-link local multiframe edge, delayed by the frame offset
  for (genvar i = 0; i < LINKS; i++)
  begin : g_link
    logic [4:0] phase;
    assign phase        = (mfFrame_q - mfOffset_q[i][4:0]) & kMask; // RQ8 RQ9
    assign localEdge[i] = phase < fpc; // RQ12

    jesd_rx_link_align u_align (
      .clk         (clk),
      .srst        (srst),
      .enable      (format_q[FMT_EN_LSB+i]),
      .localEdge   (localEdge[i]),
      .bufDelay    (bufDelay_q[i][3:0]),
      .suppressErr (linkSub_q[LSUB_LSB +: SUB_W] == SUBCLASS_0 &&
                    format_q[FMT_F_LSB +: 3] == 3'h1), // RQ5
      .laneData    (link.laneData[i]),
      .laneValid   (link.laneValid[i]),
      .laneIlas    (link.laneIlas[i]), // RQ4
      .syncReqN    (syncUp[i]),
      .sampleOut   (sampleOut[i]),
      .sampleValid (sampleValid[i]),
      .latency     (latency[i]),
      .linkUp      (linkUp[i])
    );
  end

  assign link.syncReqN = syncUp;

  // APB decode: one wait state, write takes effect with pready
  assign idx       = paddr[ADDR_W-1:2];
  assign apbAccess = psel && penable && pready;
  assign apbWrite  = apbAccess && pwrite;
  assign hit       = (paddr[1:0] == 2'b00) &&
                     (idx inside {IDX_SUBCLASS, IDX_LAT0, IDX_LAT1, IDX_MFOFS0,
                                  IDX_MFOFS1, IDX_BUFDLY0, IDX_BUFDLY1,
                                  IDX_LINK_FORMAT, IDX_STATUS, IDX_LINK_SUB});

  // Ready for one cycle after the setup phase
  always_ff @(posedge clk)
  begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // Writable registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      subclass_q <= RST_SUBCLASS;
      linkSub_q  <= RST_LINK_SUB;
      format_q   <= RST_FORMAT;
      mfOffset_q <= {LINKS{RST_MFOFS}};
      bufDelay_q <= {LINKS{RST_BUFDLY}};
    end
    else if (apbWrite)
    begin
      unique case (idx)
        IDX_SUBCLASS:    subclass_q    <= pwdata[7:0];
        IDX_LINK_SUB:    linkSub_q     <= pwdata[7:0];
        IDX_LINK_FORMAT: format_q      <= pwdata[7:0];
        IDX_MFOFS0:      mfOffset_q[0] <= pwdata[7:0]; // RQ14
        IDX_MFOFS1:      mfOffset_q[1] <= pwdata[7:0];
        IDX_BUFDLY0:     bufDelay_q[0] <= pwdata[7:0]; // RQ10
        IDX_BUFDLY1:     bufDelay_q[1] <= pwdata[7:0];
        default:         ;
      endcase
    end
  end

  // Read data and error answer, presented with pready
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= !hit;
      unique case (idx)
        IDX_SUBCLASS:    prdata <= {24'h000000, subclass_q};
        IDX_LAT0:        prdata <= {24'h000000, latency[0]}; // RQ15
        IDX_LAT1:        prdata <= {24'h000000, latency[1]};
        IDX_MFOFS0:      prdata <= {24'h000000, mfOffset_q[0]};
        IDX_MFOFS1:      prdata <= {24'h000000, mfOffset_q[1]};
        IDX_BUFDLY0:     prdata <= {24'h000000, bufDelay_q[0]};
        IDX_BUFDLY1:     prdata <= {24'h000000, bufDelay_q[1]};
        IDX_LINK_FORMAT: prdata <= {24'h000000, format_q};
        IDX_STATUS:      prdata <= {28'h0000000, sysrefSeen_q, badSub, linkUp};
        IDX_LINK_SUB:    prdata <= {24'h000000, linkSub_q};
        default:         prdata <= '0;
      endcase
    end
  end
endmodule : jesd_rx_dl

//--- verilog/jesd_dl_pkg.sv
// Shared constants for the deterministic-latency receive link
package jesd_dl_pkg;
  localparam int          LANE_W          = 32;
  localparam int          LINKS           = 2;
  localparam int          ADDR_W          = 14;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_SUBCLASS    = 12'h301;
  localparam logic [11:0] IDX_LAT0        = 12'h302;
  localparam logic [11:0] IDX_LAT1        = 12'h303;
  localparam logic [11:0] IDX_MFOFS0      = 12'h304;
  localparam logic [11:0] IDX_MFOFS1      = 12'h305;
  localparam logic [11:0] IDX_BUFDLY0     = 12'h306;
  localparam logic [11:0] IDX_BUFDLY1     = 12'h307;
  localparam logic [11:0] IDX_LINK_FORMAT = 12'h308;
  localparam logic [11:0] IDX_STATUS      = 12'h309;
  localparam logic [11:0] IDX_LINK_SUB    = 12'h458;
  // Field positions
  localparam int          SUB_LSB         = 0;
  localparam int          SUB_W           = 3;
  localparam int          LSUB_LSB        = 5;
  localparam int          FMT_F_LSB       = 0;
  localparam int          FMT_K32_BIT     = 3;
  localparam int          FMT_EN_LSB      = 4;
  localparam int          ST_UP_LSB       = 0;
  localparam int          ST_BADSUB_BIT   = 2;
  localparam int          ST_SYSREF_BIT   = 3;
  // Reset values
  localparam logic [7:0]  RST_SUBCLASS    = 8'h01;
  localparam logic [7:0]  RST_LINK_SUB    = 8'h2F;
  localparam logic [7:0]  RST_MFOFS       = 8'h00;
  localparam logic [7:0]  RST_BUFDLY      = 8'h00;
  localparam logic [7:0]  RST_FORMAT      = 8'h02;
  // Timing counts in processing-clock cycles, then subclass codes
  localparam logic [3:0]  BUF_DELAY_MAX   = 4'hA;
  localparam logic [7:0]  ILAS_CYCLES     = 8'h20;
  localparam logic [2:0]  SUBCLASS_0      = 3'h0;
  localparam logic [2:0]  SUBCLASS_1      = 3'h1;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] regAddr(input logic [11:0] idx);
    regAddr = {idx, 2'b00};
  endfunction : regAddr
endpackage : jesd_dl_pkg

//--- verilog/jesd_link_if.sv
// Lane bundle between transmitter and receiver, two links
`timescale 1ns/100ps
interface jesd_link_if;
  import jesd_dl_pkg::*;
  logic [LINKS-1:0][LANE_W-1:0] laneData;
  logic [LINKS-1:0]             laneValid;
  logic [LINKS-1:0]             laneIlas;
  logic [LINKS-1:0]             syncReqN;

  modport rx (input laneData, input laneValid, input laneIlas, output syncReqN);
  modport tx (output laneData, output laneValid, output laneIlas, input syncReqN);
endinterface : jesd_link_if

//--- verilog/jesd_rx_link_align.sv
// One link: latency capture, buffer delay, sync request
`timescale 1ns/100ps
module jesd_rx_link_align
  import jesd_dl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              enable,
  input  wire logic              localEdge,
  input  wire logic [3:0]        bufDelay,
  input  wire logic              suppressErr,
  input  wire logic [LANE_W-1:0] laneData,
  input  wire logic              laneValid,
  input  wire logic              laneIlas,
  output logic                   syncReqN,
  output logic [LANE_W-1:0]      sampleOut,
  output logic                   sampleValid,
  output logic [7:0]             latency,
  output logic                   linkUp
);
  logic [BUF_DELAY_MAX:0][LANE_W-1:0] dataPipe_q;
  logic [BUF_DELAY_MAX:0]             validPipe_q;
  logic [BUF_DELAY_MAX:0]             edgePipe_q;
  logic [3:0]                         tap;
  logic [7:0]                         procCount_q;
  logic                               ilasSeen_q;
  logic                               inData_q;
  logic                               reading_q;
  logic                               toData;
  logic                               ilasAgain;

  // Values above the maximum are clamped
  assign tap       = (bufDelay > BUF_DELAY_MAX) ? BUF_DELAY_MAX : bufDelay; // RQ10
  assign toData    = ilasSeen_q && !inData_q && laneValid && !laneIlas;
  assign ilasAgain = inData_q && laneValid && laneIlas;

  // Delay line for data, valid and the local multiframe edge
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dataPipe_q  <= '0;
      validPipe_q <= '0;
      edgePipe_q  <= '0;
    end
    else
    begin
      dataPipe_q  <= {dataPipe_q[BUF_DELAY_MAX-1:0], laneData};
      validPipe_q <= {validPipe_q[BUF_DELAY_MAX-1:0], laneValid && inData_q};
      edgePipe_q  <= {edgePipe_q[BUF_DELAY_MAX-1:0], localEdge};
    end
  end

  // Cycles since the last local multiframe edge, wraps each multiframe
  always_ff @(posedge clk)
  begin
    if (srst)
      procCount_q <= '0;
    else if (localEdge)
      procCount_q <= '0; // RQ16
    else
      procCount_q <= procCount_q + 8'h01;
  end

  // Link state: alignment sequence seen, then data phase
  always_ff @(posedge clk)
  begin
    if (srst || !enable)
    begin
      ilasSeen_q <= 1'b0;
      inData_q   <= 1'b0;
    end
    else
    begin
      if (laneValid && laneIlas && !inData_q)
        ilasSeen_q <= 1'b1;
      if (toData)
        inData_q <= 1'b1;
      else if (ilasAgain)
      begin
        inData_q   <= 1'b0;
        ilasSeen_q <= 1'b1;
      end
    end
  end

  // Latency captured at each alignment-to-data transition, held until next
  always_ff @(posedge clk)
  begin
    if (srst)
      latency <= '0;
    else if (toData)
      latency <= localEdge ? 8'h00 : procCount_q + 8'h01; // RQ15 RQ18
  end

  // Reading starts at a delayed local edge once data sits at the tap,
  // so release stays locked to the multiframe, not to lane arrival
  always_ff @(posedge clk)
  begin
    if (srst || !inData_q)
      reading_q <= 1'b0;
    else if (edgePipe_q[tap] && validPipe_q[tap])
      reading_q <= 1'b1; // RQ8 RQ11
  end

  // Samples leave through the selected delay tap
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sampleOut   <= '0;
      sampleValid <= 1'b0;
    end
    else
    begin
      sampleOut   <= dataPipe_q[tap]; // RQ11
      sampleValid <= reading_q && validPipe_q[tap];
    end
  end

  // Sync request low while the link is disabled; one-cycle low on error unless suppressed
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      syncReqN <= 1'b0;
      linkUp   <= 1'b0;
    end
    else
    begin
      syncReqN <= enable && !(ilasAgain && !suppressErr); // RQ5
      linkUp   <= inData_q;
    end
  end
endmodule : jesd_rx_link_align

//--- verilog/jesd_tx_end.sv
// Transmitter end: alignment sequence then user data per link
`timescale 1ns/100ps
module jesd_tx_end
  import jesd_dl_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [LINKS-1:0][LANE_W-1:0] sampleIn,
  jesd_link_if.tx                          link,
  output logic      [LINKS-1:0]            dataPhase
);
  typedef enum logic [1:0] {TX_IDLE, TX_ILAS, TX_DATA} txState_e;

  logic [LINKS-1:0][LANE_W-1:0] laneData_q;
  logic [LINKS-1:0]             laneValid_q;
  logic [LINKS-1:0]             laneIlas_q;

  assign link.laneData  = laneData_q;
  assign link.laneValid = laneValid_q;
  assign link.laneIlas  = laneIlas_q;

  // One sequencer per link, restarted by a sync request
  for (genvar i = 0; i < LINKS; i++)
  begin : g_tx
    txState_e   state_q;
    logic [7:0] count_q;

    always_ff @(posedge clk)
    begin
      if (srst || !link.syncReqN[i])
      begin
        state_q        <= TX_IDLE;
        count_q        <= '0;
        laneValid_q[i] <= 1'b0;
        laneIlas_q[i]  <= 1'b0;
        laneData_q[i]  <= '0;
        dataPhase[i]   <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          TX_IDLE:
          begin
            state_q        <= TX_ILAS; // RQ4
            count_q        <= '0;
            laneValid_q[i] <= 1'b1;
            laneIlas_q[i]  <= 1'b1;
          end
          TX_ILAS:
          begin
            count_q <= count_q + 8'h01;
            if (count_q == ILAS_CYCLES - 8'h01)
            begin
              state_q       <= TX_DATA;
              laneIlas_q[i] <= 1'b0;
              laneData_q[i] <= sampleIn[i];
              dataPhase[i]  <= 1'b1;
            end
          end
          TX_DATA:
            laneData_q[i] <= sampleIn[i]; // RQ7
        endcase
      end
    end
  end
endmodule : jesd_tx_end

//--- verif/jesd_link_asserts.sv
// Assertions on the lane bundle that joins the two link ends
`timescale 1ns/100ps
module jesd_link_asserts
  import jesd_dl_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         srst,
  input wire logic [LINKS-1:0][LANE_W-1:0] laneData,
  input wire logic [LINKS-1:0]             laneValid,
  input wire logic [LINKS-1:0]             laneIlas,
  input wire logic [LINKS-1:0]             syncReqN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Lane bundle handshake and alignment sequence
  idle_after_reset_a: assert property ($fell(srst) |-> syncReqN == 2'h0 && laneValid == 2'h0)
    else $error("lanes not idle after reset");
  ilas_start0_a: assert property ($rose(syncReqN[0]) |=> laneValid[0] && laneIlas[0])
    else $error("link 0 alignment sequence late");
  ilas_start1_a: assert property ($rose(syncReqN[1]) |=> laneValid[1] && laneIlas[1])
    else $error("link 1 alignment sequence late");
  ilas_len0_a: assert property ($rose(laneIlas[0]) |-> ##31 laneIlas[0] ##1 !laneIlas[0])
    else $error("link 0 alignment sequence length wrong");
  ilas_len1_a: assert property ($rose(laneIlas[1]) |-> ##31 laneIlas[1] ##1 !laneIlas[1])
    else $error("link 1 alignment sequence length wrong");
  sync_low_idle_a: assert property (!syncReqN[0] |=> !laneValid[0])
    else $error("link 0 kept sending during sync request");
  valid_holds_a: assert property (laneValid[1] && syncReqN[1] |=> laneValid[1])
    else $error("link 1 dropped valid without request");
  ilas_needs_valid_a: assert property ((laneIlas & ~laneValid) == 2'h0)
    else $error("alignment marker without valid");
  data_follows_a: assert property ($fell(laneIlas[0]) && $past(syncReqN[0]) |-> laneValid[0])
    else $error("link 0 no data after alignment sequence");

  // Main scenarios reached
  cover property (laneValid[0] && !laneIlas[0] && laneData[0] != '0);
  cover property ($fell(laneIlas[1]));
  cover property (syncReqN == 2'h3 && laneValid == 2'h3);
endmodule : jesd_link_asserts

//--- verif/jesd_rx_deterministic_latency_bench.sv
// Bench joining both link ends, register access over APB
`timescale 1ns/100ps
module jesd_rx_deterministic_latency_bench
  import jesd_dl_pkg::*;
;
  logic                         clk, srst, psel, penable, pwrite, sysrefPin, pready, pslverr, err;
  logic [ADDR_W-1:0]            paddr;
  logic [31:0]                  pwdata, prdata, rd, lat0, lat1;
  logic [LINKS-1:0][LANE_W-1:0] sampleIn, sampleOut;
  logic [LINKS-1:0]             sampleValid, linkUp, dataPhase;
  int                           failCount, compares, t0, t1, n;

  // Two ends meeting over one lane bundle
  jesd_link_if jesd_link_if_i ();
  jesd_rx_dl jesd_rx_dl_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysrefPin(sysrefPin), .link(jesd_link_if_i), .sampleOut(sampleOut),
    .sampleValid(sampleValid), .linkUp(linkUp));
  jesd_tx_end jesd_tx_end_i (.clk(clk), .srst(srst), .sampleIn(sampleIn),
    .link(jesd_link_if_i), .dataPhase(dataPhase));
  jesd_link_asserts jesd_link_asserts_i (.clk(clk), .srst(srst),
    .laneData(jesd_link_if_i.laneData), .laneValid(jesd_link_if_i.laneValid),
    .laneIlas(jesd_link_if_i.laneIlas), .syncReqN(jesd_link_if_i.syncReqN));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic giveVerdict;
    if (failCount == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : giveVerdict

  // Hang cut short
  task automatic bail;
    failCount++;
    giveVerdict();
  endtask : bail

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [1:0] lo,
                     input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, lo};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      bail();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] idx, input logic [31:0] v);
    apb(1'b1, idx, 2'h0, v);
  endtask : wr

  task automatic rdchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 2'h0, 32'h0);
    check(name, rd, exp);
  endtask : rdchk

  task automatic resetDut;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
  endtask : resetDut

  // Configure both links, enable together, time first valid of each
  task automatic bringUp(input logic [7:0] sub, input logic [7:0] lsub,
                         input logic [7:0] ofs1, input logic [7:0] dly1);
    wr(IDX_SUBCLASS, {24'h0, sub});
    wr(IDX_LINK_SUB, {24'h0, lsub});
    wr(IDX_MFOFS0, 32'h0);
    wr(IDX_MFOFS1, {24'h0, ofs1});
    wr(IDX_BUFDLY0, 32'h0);
    wr(IDX_BUFDLY1, {24'h0, dly1});
    wr(IDX_LINK_FORMAT, 32'h32);
    t0 = -1;
    t1 = -1;
    n = 0;
    while (t0 < 0 || t1 < 0)
    begin
      @(posedge clk);
      n++;
      if (t0 < 0 && sampleValid[0] === 1'b1) t0 = n;
      if (t1 < 0 && sampleValid[1] === 1'b1) t1 = n;
      if (n > 400) bail();
    end
    repeat (12) @(posedge clk);
    apb(1'b0, IDX_LAT0, 2'h0, 32'h0);
    lat0 = rd;
    apb(1'b0, IDX_LAT1, 2'h0, 32'h0);
    lat1 = rd;
    check("sample0", sampleOut[0], sampleIn[0]);
    check("sample1", sampleOut[1], sampleIn[1]);
    check("linkUp", {30'h0, linkUp}, 32'h3);
    check("dataPhase", {30'h0, dataPhase}, 32'h3);
  endtask : bringUp

  // Main sequence
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sysrefPin = 1'b0;
    sampleIn[0] = 32'hA5C30F01;
    sampleIn[1] = 32'h5A3CF0E2;
    failCount = 0;
    compares = 0;
    resetDut();
    rdchk("subclass", IDX_SUBCLASS, 32'h01);
    rdchk("linkSub", IDX_LINK_SUB, 32'h2F);
    rdchk("bufDly0", IDX_BUFDLY0, 32'h00);
    rdchk("mfOfs1", IDX_MFOFS1, 32'h00);
    wr(IDX_BUFDLY0, 32'h0F);
    rdchk("bufDlyRaw", IDX_BUFDLY0, 32'h0F);
    wr(IDX_BUFDLY1, 32'h0A);
    rdchk("bufDlyTop", IDX_BUFDLY1, 32'h0A);
    wr(IDX_MFOFS0, 32'h1A);
    rdchk("mfOfs0", IDX_MFOFS0, 32'h1A);
    wr(IDX_SUBCLASS, 32'h02);
    apb(1'b0, IDX_STATUS, 2'h0, 32'h0);
    check("badSub", {31'h0, rd[ST_BADSUB_BIT]}, 32'h1);
    apb(1'b0, IDX_LAT0, 2'h0, 32'h0);
    lat0 = rd;
    wr(IDX_LAT0, 32'hFF);
    rdchk("latReadOnly", IDX_LAT0, lat0);
    apb(1'b0, 12'h300, 2'h0, 32'h0);
    check("unmapErr", {31'h0, err}, 32'h1);
    check("unmapData", rd, 32'h0);
    apb(1'b0, IDX_SUBCLASS, 2'h2, 32'h0);
    check("misalignErr", {31'h0, err}, 32'h1);
    // Subclass 0, SYSREF idle, buffer delays 0 and 15 (used as 10)
    bringUp(8'h00, 8'h0F, 8'h00, 8'h0F);
    check("validGap", t1 - t0, 32'h0A);
    check("latEqual", lat1, lat0);
    check("latWrap", {31'h0, lat0 < 32'd8}, 32'h1);
    rdchk("linksUp", IDX_STATUS, 32'h03);
    repeat (20) @(posedge clk);
    rdchk("latHold", IDX_LAT0, lat0);
    // Subclass 1 after a second reset; link 1 one processing clock later
    resetDut();
    @(posedge clk);
    sysrefPin <= 1'b1;
    repeat (3) @(posedge clk);
    sysrefPin <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, IDX_STATUS, 2'h0, 32'h0);
    check("sysrefSeen", {31'h0, rd[ST_SYSREF_BIT]}, 32'h1);
    wr(IDX_STATUS, 32'h08);
    apb(1'b0, IDX_STATUS, 2'h0, 32'h0);
    check("sysrefClear", {31'h0, rd[ST_SYSREF_BIT]}, 32'h0);
    bringUp(8'h01, 8'h2F, 8'h02, 8'h00);
    check("latShift", lat1, (lat0 + 32'h7) & 32'h7);
    giveVerdict();
  end
endmodule : jesd_rx_deterministic_latency_bench
